// ==== hw/wdit_params.svh ====
// Purpose: Constants of the watchdog and interval timer.
// Assumes: Included by its bare name from the design files.
// Notes:   Register indices are word indices; byte address is four times the index.
`ifndef WDIT_PARAMS_SVH
`define WDIT_PARAMS_SVH

`define WDIT_ADDR_W        18
`define WDIT_IDX_CLKSEL    16'hff42
`define WDIT_IDX_IRQCTL    16'hff43
`define WDIT_IDX_COUNT     16'hff44
`define WDIT_IDX_MODE      16'hfff9

`define WDIT_MODE_GO       7
`define WDIT_MODE_HI       4
`define WDIT_MODE_ACT      3
`define WDIT_CLKSEL_LSB    0
`define WDIT_CLKSEL_MSB    2
`define WDIT_IRQ_FLAG      0
`define WDIT_IRQ_MASK      1
`define WDIT_IRQ_PRIO      2

`define WDIT_CLKSEL_RST    8'h00
`define WDIT_MODE_RST      8'h00
`define WDIT_IRQCTL_RST    8'h06

`define WDIT_PRE_W         12
`define WDIT_CNT_W         8
`define WDIT_TAP_W         4
`define WDIT_WDT_TAP_BASE  4'h3
`define WDIT_WDT_TAP_TOP   4'hb
`define WDIT_ITV_TAP_BASE  4'h4
`define WDIT_ITV_TAP_TOP   4'hc

`define WDIT_RESP_OKAY     2'h0
`define WDIT_RESP_SLVERR   2'h2

`endif

// ==== hw/wdit_pkg.sv ====
// Purpose: Types shared by the watchdog and interval timer.
// Assumes: Nothing beyond the constants header.
// Notes:   Encodings are left to the tools.
package wdit_pkg;

  typedef enum {
    WDIT_INTERVAL,
    WDIT_WDT_NMI,
    WDIT_WDT_RESET
  } wdit_mode_t;

  typedef enum {
    WDIT_WR_IDLE,
    WDIT_WR_RESP
  } wdit_wr_state_t;

  typedef enum {
    WDIT_RD_IDLE,
    WDIT_RD_RESP
  } wdit_rd_state_t;

endpackage : wdit_pkg

// ==== hw/wdit_prescaler.sv ====
// Purpose: Free-running divider of the main clock with a selectable tap.
// Assumes: tap lies between 1 and the divider width.
// Notes:   Never cleared by a restart, so the first period may run short.
`include "wdit_params.svh"
`timescale 1ns/1ps
`default_nettype none
module wdit_prescaler (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic [`WDIT_TAP_W-1:0]   tap,
  output logic                          tick
);
  logic [`WDIT_PRE_W-1:0] pre;
  logic [`WDIT_PRE_W-1:0] next_pre;
  logic [`WDIT_PRE_W-1:0] tap_mask;

  always_comb begin
    next_pre = pre + `WDIT_PRE_W'(1);
    tap_mask = `WDIT_PRE_W'((1 << tap) - 1);
    tick     = ((pre & tap_mask) == tap_mask);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre <= '0;
    end else begin
      pre <= next_pre;
    end
  end
endmodule : wdit_prescaler
`default_nettype wire

// ==== hw/wdit_counter.sv ====
// Purpose: Eight-bit count of prescaler ticks with overflow pulse.
// Assumes: clear and tick are one-cycle pulses from the same clock.
// Notes:   A clear wins over a tick in the same cycle.
`include "wdit_params.svh"
`timescale 1ns/1ps
`default_nettype none
module wdit_counter (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     clear,
  input  wire logic                     run,
  input  wire logic                     tick,
  output logic [`WDIT_CNT_W-1:0]        count,
  output logic                          ovf
);
  logic [`WDIT_CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    ovf        = 1'b0;
    if (clear) begin
      next_count = '0;
    end else if (run && tick) begin
      next_count = count + `WDIT_CNT_W'(1);
      ovf        = (count == {`WDIT_CNT_W{1'b1}});
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule : wdit_counter
`default_nettype wire

// ==== hw/wdit_top.sv ====
// Purpose: Watchdog and interval timer with an AXI4-Lite register slave.
// Assumes: All inputs synchronous to clk (50 MHz); nrst is the system reset.
// Notes:   Summary of operation follows.
// Summary of operation
// - Mode bits pick interval irq, watchdog NMI or watchdog system reset.
// - Exactly one mode is active at any time.
// - Mode bits, once set, ignore writes of zero until reset.
// - Go bit sticks at one; only reset clears it.
// - Every write of one to go clears and restarts the counter.
// - Interval mode counts once go is set and flags every overflow.
// - Watchdog periods are 2^11..2^17 clocks, code seven gives 2^19.
// - Interval periods are 2^12..2^18 clocks, code seven gives 2^20.
// - Setting the high mode bit while the flag is set raises NMI.
// - Counting goes on in HALT and stops in STOP.
// - Counting pauses while the CPU runs from the subsystem clock.
// - First period after restart may be short; prescaler is not cleared.
// - Interval request obeys mask and priority, highest default priority.
// - Reset loads zero into mode and clock select registers.
//
// The AXI4-Lite register port was left to the implementer.
`include "wdit_params.svh"
`timescale 1ns/1ps
`default_nettype none
module wdit_top (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic [`WDIT_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]               s_axi_awprot,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`WDIT_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]               s_axi_arprot,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     stop_mode,
  input  wire logic                     cpu_on_subclk,
  output logic                          wdt_maskable_irq,
  output logic                          wdt_irq_priority,
  output logic                          nmi_req,
  output logic                          sys_reset_req
);
  import wdit_pkg::*;

  localparam logic [`WDIT_ADDR_W-1:0] ADDR_CLKSEL = {`WDIT_IDX_CLKSEL, 2'b00};
  localparam logic [`WDIT_ADDR_W-1:0] ADDR_IRQCTL = {`WDIT_IDX_IRQCTL, 2'b00};
  localparam logic [`WDIT_ADDR_W-1:0] ADDR_COUNT  = {`WDIT_IDX_COUNT, 2'b00};
  localparam logic [`WDIT_ADDR_W-1:0] ADDR_MODE   = {`WDIT_IDX_MODE, 2'b00};

  // Register state.
  logic [2:0]                  clk_sel;
  logic                        wdt_mode_sel_hi;
  logic                        overflow_action_sel;
  logic                        wdt_go_bit;
  logic                        wdt_irq_flag;
  logic                        wdt_irq_mask;
  logic [2:0]                  next_clk_sel;
  logic                        next_wdt_mode_sel_hi;
  logic                        next_overflow_action_sel;
  logic                        next_wdt_go_bit;
  logic                        next_wdt_irq_flag;
  logic                        next_wdt_irq_mask;
  logic                        next_wdt_irq_priority;
  logic                        next_wdt_maskable_irq;
  logic                        next_nmi_req;
  logic                        next_sys_reset_req;

  // Write channel state.
  wdit_wr_state_t              wr_state;
  wdit_wr_state_t              next_wr_state;
  logic                        aw_held;
  logic                        w_held;
  logic [`WDIT_ADDR_W-1:0]     wr_addr;
  logic [31:0]                 wr_data;
  logic [3:0]                  wr_strb;
  logic                        next_aw_held;
  logic                        next_w_held;
  logic [`WDIT_ADDR_W-1:0]     next_wr_addr;
  logic [31:0]                 next_wr_data;
  logic [3:0]                  next_wr_strb;
  logic [1:0]                  next_bresp;
  logic                        wr_fire;

  // Read channel state.
  wdit_rd_state_t              rd_state;
  wdit_rd_state_t              next_rd_state;
  logic [31:0]                 next_rdata;
  logic [1:0]                  next_rresp;

  // Timer datapath.
  wdit_mode_t                  mode;
  logic [`WDIT_TAP_W-1:0]      tap;
  logic                        tick;
  logic                        restart;
  logic                        run;
  logic                        ovf;
  logic [`WDIT_CNT_W-1:0]      count;
  logic                        wr_mode;
  logic                        wr_clksel;
  logic                        wr_irqctl;

  // Mode decode gives one mode only, so the two uses never overlap.
  always_comb begin
    if (!wdt_mode_sel_hi) begin
      mode = WDIT_INTERVAL;
    end else if (!overflow_action_sel) begin
      mode = WDIT_WDT_NMI;
    end else begin
      mode = WDIT_WDT_RESET;
    end
  end

  // Tap selects the counter clock divide ratio for the current mode.
  always_comb begin
    if (mode == WDIT_INTERVAL) begin
      if (clk_sel == 3'h7) begin
        tap = `WDIT_ITV_TAP_TOP;
      end else begin
        tap = `WDIT_ITV_TAP_BASE + {1'b0, clk_sel};
      end
    end else begin
      if (clk_sel == 3'h7) begin
        tap = `WDIT_WDT_TAP_TOP;
      end else begin
        tap = `WDIT_WDT_TAP_BASE + {1'b0, clk_sel};
      end
    end
  end

  // HALT is not seen here at all, so counting simply continues through it.
  assign run = wdt_go_bit && !stop_mode && !cpu_on_subclk;

  // The prescaler is not cleared by a restart, which is why a restart can come up short.
  wdit_prescaler u_prescaler (
    .clk   (clk),
    .nrst  (nrst),
    .tap   (tap),
    .tick  (tick)
  );

  wdit_counter u_counter (
    .clk   (clk),
    .nrst  (nrst),
    .clear (restart),
    .run   (run),
    .tick  (tick),
    .count (count),
    .ovf   (ovf)
  );

  // Write channel: address and data are taken in either order.
  always_comb begin
    next_wr_state = wr_state;
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_wr_addr  = wr_addr;
    next_wr_data  = wr_data;
    next_wr_strb  = wr_strb;
    next_bresp    = s_axi_bresp;
    s_axi_awready = !aw_held && (wr_state == WDIT_WR_IDLE);
    s_axi_wready  = !w_held && (wr_state == WDIT_WR_IDLE);
    wr_fire       = 1'b0;
    case (wr_state)
      WDIT_WR_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          next_aw_held = 1'b1;
          next_wr_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          next_w_held  = 1'b1;
          next_wr_data = s_axi_wdata;
          next_wr_strb = s_axi_wstrb;
        end
        if (aw_held && w_held) begin
          wr_fire       = 1'b1;
          next_aw_held  = 1'b0;
          next_w_held   = 1'b0;
          next_wr_state = WDIT_WR_RESP;
          if (wr_addr == ADDR_CLKSEL || wr_addr == ADDR_MODE ||
              wr_addr == ADDR_IRQCTL || wr_addr == ADDR_COUNT) begin
            next_bresp = `WDIT_RESP_OKAY;
          end else begin
            next_bresp = `WDIT_RESP_SLVERR;
          end
        end
      end
      WDIT_WR_RESP: begin
        if (s_axi_bready) begin
          next_wr_state = WDIT_WR_IDLE;
        end
      end
      default: begin
        next_wr_state = WDIT_WR_IDLE;
      end
    endcase
  end

  // Byte lane zero carries every register; other lanes are ignored.
  assign wr_mode   = wr_fire && wr_addr == ADDR_MODE && wr_strb[0];
  assign wr_clksel = wr_fire && wr_addr == ADDR_CLKSEL && wr_strb[0];
  assign wr_irqctl = wr_fire && wr_addr == ADDR_IRQCTL && wr_strb[0];
  assign restart   = wr_mode && wr_data[`WDIT_MODE_GO];

  // Control registers and request pulses.
  always_comb begin
    next_clk_sel             = clk_sel;
    next_wdt_mode_sel_hi     = wdt_mode_sel_hi;
    next_overflow_action_sel = overflow_action_sel;
    next_wdt_go_bit          = wdt_go_bit;
    next_wdt_irq_flag        = wdt_irq_flag;
    next_wdt_irq_mask        = wdt_irq_mask;
    next_wdt_irq_priority    = wdt_irq_priority;
    next_nmi_req             = 1'b0;
    next_sys_reset_req       = 1'b0;
    if (wr_clksel) begin
      next_clk_sel = wr_data[`WDIT_CLKSEL_MSB:`WDIT_CLKSEL_LSB];
    end
    if (wr_mode) begin
      // Only ones are merged in; zeros never clear these bits.
      next_wdt_mode_sel_hi     = wdt_mode_sel_hi | wr_data[`WDIT_MODE_HI];
      next_overflow_action_sel = overflow_action_sel | wr_data[`WDIT_MODE_ACT];
      next_wdt_go_bit          = wdt_go_bit | wr_data[`WDIT_MODE_GO];
      if (wr_data[`WDIT_MODE_HI] && wdt_irq_flag) begin
        next_nmi_req = 1'b1;
      end
    end
    if (wr_irqctl) begin
      next_wdt_irq_mask     = wr_data[`WDIT_IRQ_MASK];
      next_wdt_irq_priority = wr_data[`WDIT_IRQ_PRIO];
      if (!wr_data[`WDIT_IRQ_FLAG]) begin
        next_wdt_irq_flag = 1'b0;
      end
    end
    // Overflow comes last so a set in the clearing cycle is never lost.
    if (ovf) begin
      case (mode)
        WDIT_INTERVAL: begin
          next_wdt_irq_flag = 1'b1;
        end
        WDIT_WDT_NMI: begin
          next_nmi_req = 1'b1;
        end
        WDIT_WDT_RESET: begin
          next_sys_reset_req = 1'b1;
        end
        default: begin
          next_nmi_req = 1'b0;
        end
      endcase
    end
    next_wdt_maskable_irq = next_wdt_irq_flag && !next_wdt_irq_mask &&
                            !next_wdt_mode_sel_hi;
  end

  // Read channel: one read at a time, data registered.
  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = s_axi_rdata;
    next_rresp    = s_axi_rresp;
    s_axi_arready = (rd_state == WDIT_RD_IDLE);
    case (rd_state)
      WDIT_RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_rd_state = WDIT_RD_RESP;
          next_rdata    = 32'h0000_0000;
          next_rresp    = `WDIT_RESP_OKAY;
          case (s_axi_araddr)
            ADDR_CLKSEL: begin
              next_rdata[`WDIT_CLKSEL_MSB:`WDIT_CLKSEL_LSB] = clk_sel;
            end
            ADDR_MODE: begin
              next_rdata[`WDIT_MODE_GO]  = wdt_go_bit;
              next_rdata[`WDIT_MODE_HI]  = wdt_mode_sel_hi;
              next_rdata[`WDIT_MODE_ACT] = overflow_action_sel;
            end
            ADDR_IRQCTL: begin
              next_rdata[`WDIT_IRQ_FLAG] = wdt_irq_flag;
              next_rdata[`WDIT_IRQ_MASK] = wdt_irq_mask;
              next_rdata[`WDIT_IRQ_PRIO] = wdt_irq_priority;
            end
            ADDR_COUNT: begin
              next_rdata[`WDIT_CNT_W-1:0] = count;
            end
            default: begin
              next_rresp = `WDIT_RESP_SLVERR;
            end
          endcase
        end
      end
      WDIT_RD_RESP: begin
        if (s_axi_rready) begin
          next_rd_state = WDIT_RD_IDLE;
        end
      end
      default: begin
        next_rd_state = WDIT_RD_IDLE;
      end
    endcase
  end

  assign s_axi_bvalid = (wr_state == WDIT_WR_RESP);
  assign s_axi_rvalid = (rd_state == WDIT_RD_RESP);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_state    <= WDIT_WR_IDLE;
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      wr_addr     <= '0;
      wr_data     <= 32'h0000_0000;
      wr_strb     <= 4'h0;
      s_axi_bresp <= `WDIT_RESP_OKAY;
      rd_state    <= WDIT_RD_IDLE;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `WDIT_RESP_OKAY;
    end else begin
      wr_state    <= next_wr_state;
      aw_held     <= next_aw_held;
      w_held      <= next_w_held;
      wr_addr     <= next_wr_addr;
      wr_data     <= next_wr_data;
      wr_strb     <= next_wr_strb;
      s_axi_bresp <= next_bresp;
      rd_state    <= next_rd_state;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_sel             <= 3'(`WDIT_CLKSEL_RST >> `WDIT_CLKSEL_LSB);
      wdt_mode_sel_hi     <= 1'(`WDIT_MODE_RST >> `WDIT_MODE_HI);
      overflow_action_sel <= 1'(`WDIT_MODE_RST >> `WDIT_MODE_ACT);
      wdt_go_bit          <= 1'(`WDIT_MODE_RST >> `WDIT_MODE_GO);
      wdt_irq_flag        <= 1'(`WDIT_IRQCTL_RST >> `WDIT_IRQ_FLAG);
      wdt_irq_mask        <= 1'(`WDIT_IRQCTL_RST >> `WDIT_IRQ_MASK);
      wdt_irq_priority    <= 1'(`WDIT_IRQCTL_RST >> `WDIT_IRQ_PRIO);
      wdt_maskable_irq    <= 1'b0;
      nmi_req             <= 1'b0;
      sys_reset_req       <= 1'b0;
    end else begin
      clk_sel             <= next_clk_sel;
      wdt_mode_sel_hi     <= next_wdt_mode_sel_hi;
      overflow_action_sel <= next_overflow_action_sel;
      wdt_go_bit          <= next_wdt_go_bit;
      wdt_irq_flag        <= next_wdt_irq_flag;
      wdt_irq_mask        <= next_wdt_irq_mask;
      wdt_irq_priority    <= next_wdt_irq_priority;
      wdt_maskable_irq    <= next_wdt_maskable_irq;
      nmi_req             <= next_nmi_req;
      sys_reset_req       <= next_sys_reset_req;
    end
  end
endmodule : wdit_top
`default_nettype wire

// ==== verification/wdit_top_sva.sv ====
// Purpose: Port-level checks of the watchdog and interval timer.
// Assumes: Bound to wdit_top; one clock domain.
// Notes:   Register contents are judged by the bench, not here.
`timescale 1ns/1ps
`default_nettype none
module wdit_top_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic stop_mode,
  input wire logic cpu_on_subclk,
  input wire logic wdt_maskable_irq,
  input wire logic nmi_req,
  input wire logic sys_reset_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  property p_wr_resp;
    s_wr_taken |=> s_wr_answer;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("Write answer late or early.");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("Read answer missing.");
  property p_wr_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("Write taken while answer pending.");
  property p_rd_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("Read taken while answer pending.");
  property p_nmi_pulse;
    nmi_req |=> !nmi_req;
  endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("NMI request longer than one cycle.");
  property p_rst_pulse;
    sys_reset_req |=> !sys_reset_req;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("Reset request longer than one cycle.");
  property p_one_mode;
    (nmi_req || sys_reset_req) |-> !wdt_maskable_irq;
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("Interval request during watchdog mode.");
  property p_stop;
    stop_mode [*2] |-> !sys_reset_req && !$rose(wdt_maskable_irq);
  endproperty
  a_stop: assert property (p_stop) else $error("Overflow while stopped.");
  property p_subclk;
    cpu_on_subclk [*2] |-> !sys_reset_req && !$rose(wdt_maskable_irq);
  endproperty
  a_subclk: assert property (p_subclk) else $error("Overflow on subsystem clock.");
endmodule : wdit_top_sva

bind wdit_top wdit_top_sva u_wdit_top_sva (.clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .stop_mode, .cpu_on_subclk,
  .wdt_maskable_irq, .nmi_req, .sys_reset_req);
`default_nettype wire

// ==== verification/wdit_top_tb.sv ====
// Purpose: Self-checking bench of the watchdog and interval timer.
// Assumes: Bench acts as the AXI4-Lite master; answer latency is not assumed.
// Notes:   Codes 0 and 1 keep periods short; ready lines stay high throughout.
`include "wdit_params.svh"
`timescale 1ns/1ps
`default_nettype none
module wdit_top_tb;
  localparam logic [17:0] addr_clk  = {`WDIT_IDX_CLKSEL, 2'b00};
  localparam logic [17:0] addr_irq  = {`WDIT_IDX_IRQCTL, 2'b00};
  localparam logic [17:0] addr_cnt  = {`WDIT_IDX_COUNT, 2'b00};
  localparam logic [17:0] addr_mode = {`WDIT_IDX_MODE, 2'b00};
  typedef struct packed {
    logic        wr;
    logic [17:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic [1:0]  r;
  } wdit_row_t;
  logic        clk, nrst, stop_mode, cpu_on_subclk;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        wdt_maskable_irq, wdt_irq_priority, nmi_req, sys_reset_req;
  int          err_total, n_checks, cyc, n_nmi, n_rst, t0, t1, t2, f, g, n0;
  wdit_row_t   rows [12];

  wdit_top u_wdit_top (.clk, .nrst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .stop_mode, .cpu_on_subclk, .wdt_maskable_irq, .wdt_irq_priority,
    .nmi_req, .sys_reset_req);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Pulses last one cycle, so they are counted here as well as polled in wait_ev.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (nmi_req === 1'b1) n_nmi <= n_nmi + 1;
    if (sys_reset_req === 1'b1) n_rst <= n_rst + 1;
    if (cyc == 90000) begin
      err_total++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic axi_wr(input logic [17:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [17:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : axi_rd

  task automatic wait_ev(input int which, output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (n < 20000 && (which == 0 ? wdt_maskable_irq : which == 1 ? nmi_req : sys_reset_req) !== 1'b1);
    t = cyc;
    chk("event seen", 32'h1, {31'h0, n < 20000});
  endtask : wait_ev

  task automatic itv_gap(input logic [31:0] code, output int first, output int gap);
    axi_wr(addr_clk, code);
    axi_wr(addr_irq, 32'h04);
    axi_wr(addr_mode, 32'h80);
    t0 = cyc;
    wait_ev(0, t1);
    axi_wr(addr_irq, 32'h04);
    repeat (3) @(posedge clk);
    chk("request after flag clear", 32'h0, {31'h0, wdt_maskable_irq});
    wait_ev(0, t2);
    first = t1 - t0;
    gap = t2 - t1;
  endtask : itv_gap

  task automatic results();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    {err_total, n_checks, cyc, n_nmi, n_rst} = '0;
    {nrst, stop_mode, cpu_on_subclk, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    rows = '{'{1'b0, addr_clk, 32'h0, 32'h0, 2'h0}, '{1'b0, addr_mode, 32'h0, 32'h0, 2'h0},
             '{1'b0, addr_irq, 32'h0, 32'h6, 2'h0}, '{1'b1, addr_clk, 32'h7, 32'h0, 2'h0},
             '{1'b0, addr_clk, 32'h0, 32'h7, 2'h0}, '{1'b1, addr_clk, 32'h0, 32'h0, 2'h0},
             '{1'b1, addr_mode, 32'h67, 32'h0, 2'h0}, '{1'b0, addr_mode, 32'h0, 32'h0, 2'h0},
             '{1'b1, addr_cnt, 32'h55, 32'h0, 2'h0}, '{1'b0, addr_cnt, 32'h0, 32'h0, 2'h0},
             '{1'b1, 18'h00100, 32'h1, 32'h0, 2'h2}, '{1'b0, 18'h00100, 32'h0, 32'h0, 2'h2}};
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("priority after reset", 32'h1, {31'h0, wdt_irq_priority});
    foreach (rows[i]) begin
      if (rows[i].wr) axi_wr(rows[i].a, rows[i].d);
      else axi_rd(rows[i].a);
      if (!rows[i].wr) chk("row read data", rows[i].x, rd);
      chk("row response", {30'h0, rows[i].r}, {30'h0, rs});
    end
    itv_gap(32'h0, f, g);
    chk("first interval", 32'h1, {31'h0, f >= 4076 && f <= 4100});
    chk("interval period code 0", 32'd4096, 32'(g));
    axi_wr(addr_irq, 32'h03);
    repeat (3) @(posedge clk);
    chk("masked request", 32'h0, {31'h0, wdt_maskable_irq});
    chk("priority output", 32'h0, {31'h0, wdt_irq_priority});
    axi_rd(addr_irq);
    chk("irq control", 32'h3, rd);
    axi_wr(addr_mode, 32'h00);
    axi_rd(addr_mode);
    chk("go bit kept", 32'h80, rd);
    n0 = n_nmi;
    axi_wr(addr_mode, 32'h90);
    repeat (3) @(posedge clk);
    chk("nmi on mode set with flag", 32'h1, 32'(n_nmi - n0));
    axi_wr(addr_irq, 32'h00);
    n0 = n_nmi;
    repeat (4) begin
      repeat (1500) @(posedge clk);
      axi_wr(addr_mode, 32'h90);
    end
    chk("no nmi while restarted", 32'h0, 32'(n_nmi - n0));
    t0 = cyc;
    wait_ev(1, t1);
    chk("watchdog period", 32'h1, {31'h0, t1 - t0 >= 2026 && t1 - t0 <= 2052});
    repeat (3) @(posedge clk);
    chk("no interval request", 32'h0, {31'h0, wdt_maskable_irq});
    axi_wr(addr_mode, 32'h90);
    n0 = n_nmi;
    stop_mode <= 1'b1;
    repeat (5000) @(posedge clk);
    chk("frozen in stop", 32'h0, 32'(n_nmi - n0));
    stop_mode <= 1'b0;
    cpu_on_subclk <= 1'b1;
    repeat (5000) @(posedge clk);
    chk("frozen on subclock", 32'h0, 32'(n_nmi - n0));
    cpu_on_subclk <= 1'b0;
    axi_wr(addr_mode, 32'h88);
    axi_wr(addr_mode, 32'h80);
    axi_rd(addr_mode);
    chk("mode bits kept", 32'h98, rd);
    n0 = n_nmi;
    wait_ev(2, t1);
    chk("no nmi with reset action", 32'h0, 32'(n_nmi - n0));
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    axi_rd(addr_mode);
    chk("mode after reset", 32'h0, rd);
    itv_gap(32'h1, f, g);
    chk("interval period code 1", 32'd8192, 32'(g));
    results();
  end
endmodule : wdit_top_tb
`default_nettype wire
